// [pkg/cra_pkg.sv]
// Purpose: shared constants and types for the reflection amplitude bank
// Assumes: apb with 32-bit data, word-aligned registers, one clock
// Notes: register offsets are word indexes; byte address is index * 4
package cra_pkg;
  // bus geometry
  localparam int CRA_ADDR_W = 12;
  localparam int CRA_DATA_W = 32;
  localparam int CRA_IDX_W = 10;
  // amplitude field geometry
  localparam int CRA_AMP_W = 7;
  localparam int CRA_NUM_PEAKS = 14;
  localparam int CRA_NUM_PAIRS = 7;
  localparam int CRA_LO_LSB = 0;
  localparam int CRA_HI_LSB = 8;
  localparam int CRA_RSVD_LO_BIT = 7;
  localparam int CRA_RSVD_HI_BIT = 15;
  localparam logic [CRA_AMP_W-1:0] CRA_AMP_RESET = 7'h00;
  // register indexes (byte address is index shifted left by two)
  localparam logic [CRA_IDX_W-1:0] CRA_IDX_PAIR_1 = 10'h19a;
  localparam logic [CRA_IDX_W-1:0] CRA_IDX_PAIR_2 = 10'h19b;
  localparam logic [CRA_IDX_W-1:0] CRA_IDX_PAIR_3 = 10'h19c;
  localparam logic [CRA_IDX_W-1:0] CRA_IDX_PAIR_4 = 10'h19d;
  localparam logic [CRA_IDX_W-1:0] CRA_IDX_PAIR_5 = 10'h19e;
  localparam logic [CRA_IDX_W-1:0] CRA_IDX_PAIR_6 = 10'h19f;
  localparam logic [CRA_IDX_W-1:0] CRA_IDX_PAIR_7 = 10'h1a0;
  localparam logic [CRA_IDX_W-1:0] CRA_IDX_CTRL = 10'h1a8;
  localparam logic [CRA_IDX_W-1:0] CRA_IDX_CAPT = 10'h1a9;
  // control register layout
  localparam int CRA_CTRL_FREEZE_BIT = 0;
  localparam logic CRA_CTRL_RESET = 1'b0;
  localparam logic [CRA_NUM_PEAKS-1:0] CRA_CAPT_RESET = 14'h0000;
  localparam logic [CRA_DATA_W-1:0] CRA_WORD_ZERO = 32'h0000_0000;
  // engine to bank write port
  typedef struct packed {
    logic run_start;
    logic [CRA_NUM_PEAKS-1:0] strobe;
    logic [CRA_AMP_W-1:0] value;
  } cra_peak_wr_t;
  // apb answer sequencer
  typedef enum logic [1:0] {
    CRA_ST_IDLE = 2'b00,
    CRA_ST_RESP = 2'b01
  } cra_apb_state_t;
endpackage

// [logic/cra_amp_field.sv]
// Purpose: one 7-bit reflection amplitude holding register
// Assumes: capture and clear come from logic on pclk
// Notes: a capture in the same cycle as a clear wins
module cra_amp_field
  import cra_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clear,
  input wire logic capture,
  input wire logic [CRA_AMP_W-1:0] value,
  output logic [CRA_AMP_W-1:0] amp
);
  // new measurement beats the run clear so no peak is lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      amp <= CRA_AMP_RESET;
    end else if (capture) begin
      amp <= value;
    end else if (clear) begin
      amp <= CRA_AMP_RESET;
    end
  end
endmodule

// [logic/cra_regs.sv]
// Purpose: apb bank of reflection amplitude registers fed by the reflectometry engine
// Assumes: engine write port runs on pclk; apb master follows the apb protocol
// Notes: every apb access answers after one wait state
module cra_regs
  import cra_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [CRA_ADDR_W-1:0] paddr,
  input wire logic [CRA_DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [2:0] pprot,
  input wire cra_peak_wr_t peak_wr,
  output logic [CRA_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic freeze
);
  cra_apb_state_t state;
  cra_apb_state_t next_state;
  logic [CRA_AMP_W-1:0] amp [CRA_NUM_PEAKS];
  logic [CRA_NUM_PEAKS-1:0] captured;
  logic [CRA_NUM_PEAKS-1:0] next_captured;
  logic [CRA_DATA_W-1:0] pair_word [CRA_NUM_PAIRS];
  logic [CRA_DATA_W-1:0] read_word;
  logic read_hit;

  // address decode: only aligned words map, the rest answer with pslverr
  wire [CRA_IDX_W-1:0] acc_idx = paddr[CRA_ADDR_W-1:2];
  wire acc_aligned = (paddr[1:0] == 2'b00);
  wire acc_pair = acc_aligned && (acc_idx >= CRA_IDX_PAIR_1) && (acc_idx <= CRA_IDX_PAIR_7);
  wire [CRA_IDX_W-1:0] pair_off = acc_idx - CRA_IDX_PAIR_1;
  wire [2:0] pair_sel = pair_off[2:0];
  wire acc_ctrl = acc_aligned && (acc_idx == CRA_IDX_CTRL);
  wire acc_capt = acc_aligned && (acc_idx == CRA_IDX_CAPT);
  wire acc_start = psel && penable && (state == CRA_ST_IDLE);
  wire acc_done = psel && penable && pready;
  // writes only ever land in the control word; amplitude words drop them
  wire ctrl_we = acc_done && pwrite && acc_ctrl && pstrb[0];
  wire next_freeze = ctrl_we ? pwdata[CRA_CTRL_FREEZE_BIT] : freeze;
  // freeze lets software read a stable snapshot while the engine keeps running
  wire cap_en = !freeze;
  wire run_clr = peak_wr.run_start && !freeze;
  wire [CRA_NUM_PEAKS-1:0] cap_vec = peak_wr.strobe & {CRA_NUM_PEAKS{cap_en}};

  // one holding register per peak; field k sits in pair k/2, half k%2
  genvar gk;
  generate
    for (gk = 0; gk < CRA_NUM_PEAKS; gk++) begin : g_peak
      cra_amp_field u_field (
        .pclk(pclk),
        .presetn(presetn),
        .clear(run_clr),
        .capture(cap_vec[gk]),
        .value(peak_wr.value),
        .amp(amp[gk])
      );
    end
  endgenerate

  // pair words: reserved bits and upper half tied low
  genvar gr;
  generate
    for (gr = 0; gr < CRA_NUM_PAIRS; gr++) begin : g_pair
      assign pair_word[gr] = {16'h0000, 1'b0, amp[2*gr+1], 1'b0, amp[2*gr]};
    end
  endgenerate

  // captured-peak map: set wins over the run clear
  assign next_captured = (run_clr ? CRA_CAPT_RESET : captured) | cap_vec;

  // read selection
  always_comb begin
    read_word = CRA_WORD_ZERO;
    read_hit = 1'b1;
    if (acc_pair) begin
      read_word = pair_word[pair_sel];
    end else if (acc_ctrl) begin
      read_word = {{(CRA_DATA_W-1){1'b0}}, freeze};
    end else if (acc_capt) begin
      read_word = {{(CRA_DATA_W-CRA_NUM_PEAKS){1'b0}}, captured};
    end else begin
      read_hit = 1'b0;
    end
  end

  // answer sequencer: one wait cycle, then pready for one cycle
  always_comb begin
    next_state = state;
    case (state)
      CRA_ST_IDLE: begin
        if (acc_start) begin
          next_state = CRA_ST_RESP;
        end
      end
      CRA_ST_RESP: begin
        next_state = CRA_ST_IDLE;
      end
      default: begin
        next_state = CRA_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= CRA_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // bus outputs come from flops; prdata returns zero on writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= CRA_WORD_ZERO;
    end else begin
      pready <= acc_start;
      pslverr <= acc_start && !read_hit;
      prdata <= (acc_start && !pwrite) ? read_word : CRA_WORD_ZERO;
    end
  end

  // control and capture state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freeze <= CRA_CTRL_RESET;
      captured <= CRA_CAPT_RESET;
    end else begin
      freeze <= next_freeze;
      captured <= next_captured;
    end
  end

  // checks: read data was latched one cycle before the answer, so compare with $past
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  wire rd_done = acc_done && !pwrite;
  wire quiet = (peak_wr.strobe == 14'h0000) && !peak_wr.run_start;

  // channel a peak 0 in the low half of the first pair
  a_pair1_low_map: assert property (
    rd_done && (acc_idx == CRA_IDX_PAIR_1) && acc_aligned
    |-> prdata[CRA_LO_LSB +: CRA_AMP_W] == $past(amp[0]))
    else $error("pair 1 low half is not channel a peak 0");

  // channel a peak 4 low and channel b peak 0 high share pair 3
  a_pair3_split_map: assert property (
    rd_done && (acc_idx == CRA_IDX_PAIR_3) && acc_aligned
    |-> (prdata[CRA_HI_LSB +: CRA_AMP_W] == $past(amp[5]))
        && (prdata[CRA_LO_LSB +: CRA_AMP_W] == $past(amp[4])))
    else $error("pair 3 does not carry a4 and b0");

  // channel b peaks 3 and 4 in pair 5
  a_pair5_chan_b: assert property (
    rd_done && (acc_idx == CRA_IDX_PAIR_5) && acc_aligned
    |-> (prdata[CRA_HI_LSB +: CRA_AMP_W] == $past(amp[9]))
        && (prdata[CRA_LO_LSB +: CRA_AMP_W] == $past(amp[8])))
    else $error("pair 5 does not carry b3 and b4");

  // channel c peaks 2 and 3 in the last pair
  a_pair7_chan_c: assert property (
    rd_done && (acc_idx == CRA_IDX_PAIR_7) && acc_aligned
    |-> (prdata[CRA_HI_LSB +: CRA_AMP_W] == $past(amp[13]))
        && (prdata[CRA_LO_LSB +: CRA_AMP_W] == $past(amp[12])))
    else $error("pair 7 does not carry c2 and c3");

  // whole-word layout of pair 4
  a_pair4_layout: assert property (
    rd_done && (acc_idx == CRA_IDX_PAIR_4) && acc_aligned
    |-> prdata == {16'h0000, 1'b0, $past(amp[7]), 1'b0, $past(amp[6])})
    else $error("pair 4 word layout wrong");

  // reserved and upper bits of any pair read zero
  a_rsvd_bits_zero: assert property (
    rd_done && acc_pair
    |-> !prdata[CRA_RSVD_HI_BIT] && !prdata[CRA_RSVD_LO_BIT]
        && (prdata[CRA_DATA_W-1:16] == 16'h0000))
    else $error("reserved bit of a pair reads non-zero");

  // a write to an amplitude word leaves fields 0 and 13 and the capture map alone
  a_write_no_effect: assert property (
    acc_done && pwrite && acc_pair && quiet
    |=> ($stable(captured) && (amp[0] == $past(amp[0]))
         && (amp[13] == $past(amp[13]))))
    else $error("apb write disturbed a stored amplitude");

  // fields stay zero until the engine writes one
  a_zero_until_strobe: assert property (
    (amp[2] == CRA_AMP_RESET) && !cap_vec[2]
    |=> amp[2] == CRA_AMP_RESET)
    else $error("amplitude left zero without a strobe");

  // a strobe latches the magnitude, which then holds unchanged through two quiet cycles with no access
  a_strobe_latch: assert property (
    cap_vec[3] ##1 (quiet && !acc_done) [*2]
    |-> (amp[3] == $past(peak_wr.value, 2)) && captured[3])
    else $error("strobed amplitude not held");

  // magnitude read back equals what was latched
  a_read_magnitude: assert property (
    cap_vec[11] ##1 quiet [*2] ##1 (rd_done && (acc_idx == CRA_IDX_PAIR_6) && acc_aligned)
    |-> prdata[CRA_HI_LSB +: CRA_AMP_W] == $past(peak_wr.value, 3))
    else $error("read magnitude differs from latched value");

  // a new run clears unstrobed fields in one cycle
  a_run_clears: assert property (
    run_clr && !cap_vec[13]
    |=> (amp[13] == CRA_AMP_RESET) && !captured[13])
    else $error("run start did not clear the field");

  // frozen bank ignores the engine
  a_freeze_holds: assert property (
    freeze && !ctrl_we |=> $stable(captured) && (amp[1] == $past(amp[1])))
    else $error("frozen bank changed");

  // every access answers exactly one cycle after it starts
  a_answer_timing: assert property (
    acc_start |=> pready ##1 !pready)
    else $error("apb answer timing wrong");

  // unmapped words answer with an error and zero data
  a_unmapped_err: assert property (
    acc_start && !read_hit |=> pslverr && (prdata == CRA_WORD_ZERO))
    else $error("unmapped access not flagged");

  // channel a peak 1 in the high half of the first pair
  a_pair1_high_map: assert property (
    rd_done && (acc_idx == CRA_IDX_PAIR_1) && acc_aligned
    |-> prdata[CRA_HI_LSB +: CRA_AMP_W] == $past(amp[1]))
    else $error("pair 1 high half is not channel a peak 1");

  // channel a peaks 2 and 3 in the second pair
  a_pair2_chan_a: assert property (
    rd_done && (acc_idx == CRA_IDX_PAIR_2) && acc_aligned
    |-> (prdata[CRA_HI_LSB +: CRA_AMP_W] == $past(amp[3]))
        && (prdata[CRA_LO_LSB +: CRA_AMP_W] == $past(amp[2])))
    else $error("pair 2 does not carry a2 and a3");

  // channel c peaks 0 and 1 in the sixth pair
  a_pair6_chan_c: assert property (
    rd_done && (acc_idx == CRA_IDX_PAIR_6) && acc_aligned
    |-> (prdata[CRA_HI_LSB +: CRA_AMP_W] == $past(amp[11]))
        && (prdata[CRA_LO_LSB +: CRA_AMP_W] == $past(amp[10])))
    else $error("pair 6 does not carry c0 and c1");

  // control word reads back the freeze bit alone
  a_ctrl_readback: assert property (
    rd_done && acc_ctrl
    |-> prdata == {{(CRA_DATA_W-1){1'b0}}, $past(freeze)})
    else $error("control word read back wrong");

  // capture map reads back the strobed-field bits
  a_capt_readback: assert property (
    rd_done && acc_capt
    |-> prdata == {{(CRA_DATA_W-CRA_NUM_PEAKS){1'b0}}, $past(captured)})
    else $error("capture map read back wrong");

  // write answers carry no data
  a_write_zero_data: assert property (
    acc_done && pwrite
    |-> prdata == CRA_WORD_ZERO)
    else $error("write answer carries data");

  // outside the answer cycle the bus outputs rest at zero
  a_idle_outputs_zero: assert property (
    !pready
    |-> !pslverr && (prdata == CRA_WORD_ZERO))
    else $error("bus output active outside answer");

  // pready never stands for two cycles
  a_pready_pulse: assert property (
    pready
    |=> !pready)
    else $error("pready held longer than one cycle");

  // pready only answers an access that was taken
  a_ready_asked: assert property (
    pready
    |-> $past(acc_start))
    else $error("pready without an access");

  // mapped words answer without error, writes to read-only words too
  a_mapped_no_err: assert property (
    acc_start && (acc_pair || acc_ctrl || acc_capt)
    |=> !pslverr)
    else $error("mapped access flagged as error");

  // byte-offset addresses are refused
  a_unaligned_refused: assert property (
    acc_start && !acc_aligned
    |=> pslverr && pready)
    else $error("unaligned access not refused");

  // control write moves freeze at the answer edge
  a_freeze_follows_ctrl: assert property (
    ctrl_we
    |=> freeze == $past(pwdata[CRA_CTRL_FREEZE_BIT]))
    else $error("freeze did not take the written bit");

  // nothing else moves freeze
  a_freeze_only_ctrl: assert property (
    !ctrl_we
    |=> $stable(freeze))
    else $error("freeze changed without a control write");

  // a strobe latches the field and marks it captured
  a_capture_sets_map: assert property (
    cap_vec[7]
    |=> captured[7] && (amp[7] == $past(peak_wr.value)))
    else $error("strobe did not latch field 7");

  // strobe and run start together: the strobed field keeps the value
  a_set_beats_clear: assert property (
    cap_vec[0] && run_clr
    |=> captured[0] && (amp[0] == $past(peak_wr.value)))
    else $error("run clear beat a same-cycle strobe");

  // without strobe or run a field holds its value
  a_hold_no_event: assert property (
    !run_clr && !cap_vec[9]
    |=> amp[9] == $past(amp[9]))
    else $error("field changed without an engine event");

  // the answer state lasts one cycle
  a_seq_returns: assert property (
    state == CRA_ST_RESP
    |=> state == CRA_ST_IDLE)
    else $error("sequencer stuck in answer state");

  c_read_pair: cover property (rd_done && acc_pair && (prdata != CRA_WORD_ZERO));
  c_write_ignored: cover property (acc_done && pwrite && acc_pair);
  c_strobe_run_same: cover property (cap_vec[0] && run_clr);
  c_freeze_read: cover property (freeze && rd_done && acc_pair);
  c_refused_access: cover property (pready && pslverr);
endmodule

// [testbench/cra_regs_tb_top.sv]
// Purpose: self-checking bench for the reflection amplitude register bank
// Assumes: apb master model below, engine port driven directly by the bench
// Notes: pstrb and pprot are held at fixed values; pprot is ignored anyway
module cra_regs_tb_top;
  import cra_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [CRA_ADDR_W-1:0] paddr = '0;
  logic [CRA_DATA_W-1:0] pwdata = '0;
  logic [3:0] pstrb = 4'hf;
  logic [2:0] pprot = 3'h0;
  cra_peak_wr_t peak_wr = '0;
  logic [CRA_DATA_W-1:0] prdata;
  logic pready;
  logic pslverr;
  logic freeze;
  int miscompares = 0;
  int checks_done = 0;
  logic [CRA_DATA_W-1:0] rdat;
  logic rerr;

  // 250 MHz clock
  always #2 pclk = ~pclk;

  cra_regs dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pprot(pprot), .peak_wr(peak_wr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .freeze(freeze)
  );

  task automatic results();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer; entered just after a rising edge, leaves one edge after release
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      miscompares++;
      $display("BAD %0t no pready", $time);
      results();
    end else begin
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask

  // read and compare data and error flag together
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic eerr);
    apb(1'b0, a, 32'h0000_0000);
    chk({rerr, rdat}, {eerr, exp});
  endtask

  // distinct values with bit 6 set so the reserved bits sit beside ones
  function automatic logic [6:0] fv(input int k);
    return 7'h71 + 7'(k);
  endfunction

  function automatic logic [31:0] pair_exp(input int i);
    return {16'h0000, 1'b0, fv(2 * i + 1), 1'b0, fv(2 * i)};
  endfunction

  // back-to-back one-cycle strobes, one field per cycle
  task automatic strobe_all();
    for (int k = 0; k < CRA_NUM_PEAKS; k++) begin
      peak_wr.strobe <= 14'h0001 << k;
      peak_wr.value <= fv(k);
      @(posedge pclk);
    end
    peak_wr <= '0;
    @(posedge pclk);
  endtask

  // one strobe, then the caller's next step starts at once
  task automatic strobe_one(input int k, input logic [6:0] v);
    peak_wr.strobe <= 14'h0001 << k;
    peak_wr.value <= v;
    @(posedge pclk);
    peak_wr <= '0;
  endtask

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // every pair reads zero after reset
    for (int i = 0; i < CRA_NUM_PAIRS; i++) rd(12'h668 + 12'(4 * i), 32'h0, 1'b0);
    // fill all fourteen fields and read back the packing
    strobe_all();
    for (int i = 0; i < CRA_NUM_PAIRS; i++) rd(12'h668 + 12'(4 * i), pair_exp(i), 1'b0);
    // writes of all ones must change nothing, reserved bits stay zero
    for (int i = 0; i < CRA_NUM_PAIRS; i++) begin
      apb(1'b1, 12'h668 + 12'(4 * i), 32'hffff_ffff);
      chk({rerr, rdat}, 33'h0);
      rd(12'h668 + 12'(4 * i), pair_exp(i), 1'b0);
    end
    // unmapped and unaligned accesses are refused
    rd(12'h000, 32'h0, 1'b1);
    rd(12'h669, 32'h0, 1'b1);
    // a new run clears the stored amplitudes; a strobe in the same cycle wins
    peak_wr <= '{run_start: 1'b1, strobe: 14'h0001, value: 7'h33};
    @(posedge pclk);
    peak_wr <= '0;
    @(posedge pclk);
    for (int i = 0; i < CRA_NUM_PAIRS; i++) begin
      rd(12'h668 + 12'(4 * i), (i == 0) ? 32'h0000_0033 : 32'h0, 1'b0);
    end
    rd(12'h6a4, 32'h0000_0001, 1'b0);
    // freeze blocks the engine strobes
    apb(1'b1, 12'h6a0, 32'h0000_0001);
    chk({32'h0, freeze}, 33'h1);
    rd(12'h6a0, 32'h0000_0001, 1'b0);
    strobe_all();
    rd(12'h668, 32'h0000_0033, 1'b0);
    apb(1'b1, 12'h6a0, 32'h0000_0000);
    chk({32'h0, freeze}, 33'h0);
    strobe_all();
    strobe_one(3, 7'h2a);
    rd(12'h66c, {16'h0000, 1'b0, 7'h2a, 1'b0, fv(2)}, 1'b0);
    strobe_one(11, 7'h15);
    rd(12'h67c, {16'h0000, 1'b0, 7'h15, 1'b0, fv(10)}, 1'b0);
    rd(12'h680, pair_exp(6), 1'b0);
    results();
  end
endmodule
